// [gotu_pkg.sv]
// General output toggle unit: shared constants, types and register map.
// Assumes an APB slave with 32-bit data and a 12-bit byte address.
//
// Summary of operation
// [R01] Link select 1 ignores all field counters; toggles run only when the fire bit is set.
// [R02] Link select 4 compares toggle field positions with the mode counter.
// [R03] Link select 5 follows the primary field counter and repeats with it.
// [R04] Link select 6 follows the secondary field counter and repeats with it.
// [R05] An 8-bit manual fire field, one bit per signal, used with link select 1.
// [R06] Start level is loaded only while the link select is 0.
// [R07] Source select 1 (default) puts the routed toggle signal on the pin.
// [R08] Source select 0 shows substrate copy on pin 4, extra vertical clocks on 5 to 8.
// [R09] Drive enable 1 drives the pin; 0 (default) leaves it undriven.
// [R10] Route enable picks the pair table result or the plain toggle signal per pin.
// [R11] Each signal pair 1/2, 3/4, 5/6, 7/8 has its own 4-bit table.
// [R12] Table output is bit (high x 2 + low); 0x06 xor, 0x08 and, 0x0E or.
// [R13] Each toggle holds a 13-bit field position compared with the linked count.
// [R14] Each toggle holds 13-bit line and pixel positions within its field.
// [R15] Internal view with low source select shows clock, clamp pulse, sample clock on pins 1-3.
// [R16] Manual mode gives up to four toggles, only in the field after the trigger.
// [R17] Fire bits sit at bits 13 to 6 of index 0x70 and arm the next field.
// [R18] Software sets every manual toggle field position to 1.
// [R19] Software rewrites the fire bits in every field where toggles should repeat.
// [R20] Software returns link select to 0 one field before reusing value 1.
// [R21] The fire field clears itself at the start of every field; a fire bit written in the sync cycle stays set.
// [R22] For link selects 5 and 6, no toggle at field 1 disables the whole signal.
// [R23] A signal inverts when field, line and pixel match a pending toggle.

package gotu_pkg;

	// ----------------------------------------------------------------
	// Sizes
	// ----------------------------------------------------------------
	localparam int GOTU_NSIG = 8;
	localparam int GOTU_NTOG = 4;
	localparam int GOTU_NPAIR = 4;
	localparam int GOTU_POS_W = 13;
	localparam int GOTU_NPOS = GOTU_NSIG * GOTU_NTOG;

	// ----------------------------------------------------------------
	// Register indices; the byte address is four times the index
	// ----------------------------------------------------------------
	localparam logic [9:0] GOTU_IDX_FIRE = 10'h070;
	localparam logic [9:0] GOTU_IDX_LINK = 10'h073;
	localparam logic [9:0] GOTU_IDX_PINCFG = 10'h075;
	localparam logic [9:0] GOTU_IDX_STATUS = 10'h07A;
	localparam logic [9:0] GOTU_IDX_TABLE = 10'h07B;
	localparam logic [2:0] GOTU_IDX_POS_TOP = 3'h1;
	localparam logic [1:0] GOTU_COMP_FIELD = 2'h0;
	localparam logic [1:0] GOTU_COMP_LINE = 2'h1;
	localparam logic [1:0] GOTU_COMP_PIXEL = 2'h2;
	localparam logic [1:0] GOTU_COMP_NONE = 2'h3;

	// ----------------------------------------------------------------
	// Field positions and reset values
	// ----------------------------------------------------------------
	localparam int GOTU_FIRE_LSB = 6;
	localparam int GOTU_PINCFG_SRC_LSB = 8;
	localparam int GOTU_PINCFG_DRV_LSB = 16;
	localparam int GOTU_PINCFG_VIEW_BIT = 24;
	localparam int GOTU_TABLE_LSB = 8;
	localparam int GOTU_STATUS_PIN_LSB = 8;
	localparam logic [7:0] GOTU_RST_SRC_SEL = 8'hFF;
	localparam logic [7:0] GOTU_RST_DRV_EN = 8'h00;
	localparam logic [12:0] GOTU_MANUAL_FIELD = 13'h0001;

	// ----------------------------------------------------------------
	// Types
	// ----------------------------------------------------------------
	typedef enum logic [2:0] {
		GOTU_LINK_IDLE = 3'h0,
		GOTU_LINK_MANUAL = 3'h1,
		GOTU_LINK_TEST2 = 3'h2,
		GOTU_LINK_TEST3 = 3'h3,
		GOTU_LINK_MODE = 3'h4,
		GOTU_LINK_PRI = 3'h5,
		GOTU_LINK_SEC = 3'h6,
		GOTU_LINK_KEEP_ON = 3'h7
	} gotu_link_t;

	typedef enum logic [1:0] {
		GOTU_BUS_IDLE = 2'b00,
		GOTU_BUS_MEMWAIT = 2'b01,
		GOTU_BUS_DONE = 2'b11
	} gotu_bus_st_t;

	typedef struct packed {
		logic [GOTU_POS_W-1:0] field;
		logic [GOTU_POS_W-1:0] line;
		logic [GOTU_POS_W-1:0] pixel;
	} gotu_pos_t;

endpackage : gotu_pkg

// [gotu_pos_mem.sv]
// Toggle position store: field, line and pixel word per toggle.
// Assumes one writer and one reader per cycle; read data is registered.
`timescale 1ns/1ps

module gotu_pos_mem #(
	parameter int DEPTH = 32
) (
	input wire logic CLK_SYS_I,
	input wire logic RST_B_I,
	input wire logic wr_en_i,
	input wire logic [$clog2(DEPTH)-1:0] wr_addr_i,
	input wire logic [1:0] wr_comp_i,
	input wire logic [gotu_pkg::GOTU_POS_W-1:0] wr_data_i,
	input wire logic rd_en_i,
	input wire logic [$clog2(DEPTH)-1:0] rd_addr_i,
	output gotu_pkg::gotu_pos_t rd_data_o
);
	import gotu_pkg::*;

	logic [GOTU_POS_W-1:0] field_mem [DEPTH];
	logic [GOTU_POS_W-1:0] line_mem [DEPTH];
	logic [GOTU_POS_W-1:0] pixel_mem [DEPTH];
	gotu_pos_t rd_data_ff;

	generate
		if (DEPTH < 2)
		begin : g_bad_depth
			$error("gotu_pos_mem depth must be at least 2");
		end
	endgenerate

	always_ff @(posedge CLK_SYS_I)
	begin
		if (wr_en_i && wr_comp_i == GOTU_COMP_FIELD)
			field_mem[wr_addr_i] <= wr_data_i; // [R13]
		if (wr_en_i && wr_comp_i == GOTU_COMP_LINE)
			line_mem[wr_addr_i] <= wr_data_i; // [R14]
		if (wr_en_i && wr_comp_i == GOTU_COMP_PIXEL)
			pixel_mem[wr_addr_i] <= wr_data_i; // [R14]
	end

	always_ff @(posedge CLK_SYS_I or negedge RST_B_I)
	begin
		if (!RST_B_I)
			rd_data_ff <= '0;
		else if (rd_en_i)
			rd_data_ff <= '{field: field_mem[rd_addr_i], line: line_mem[rd_addr_i], pixel: pixel_mem[rd_addr_i]};
	end

	assign rd_data_o = rd_data_ff;

endmodule : gotu_pos_mem

// [gotu_pair_lut.sv]
// Two-input logic table for one pair of toggle signals.
// Assumes the table word is stable; purely combinational.
`timescale 1ns/1ps

module gotu_pair_lut (
	input wire logic [3:0] table_i,
	input wire logic lo_i,
	input wire logic hi_i,
	output logic res_o
);
	import gotu_pkg::*;

	assign res_o = table_i[{hi_i, lo_i}]; // [R12]

endmodule : gotu_pair_lut

// [gotu_top.sv]
// General output toggle unit: register file, toggle scanner and pin mux.
// Assumes the field, line and pixel counters come from the timing generator
// and the field counters are stable except at the field sync pulse.
`timescale 1ns/1ps

module gotu_top (
	input wire logic CLK_SYS_I,
	input wire logic RST_B_I,
	input wire logic PSEL_I,
	input wire logic PENABLE_I,
	input wire logic PWRITE_I,
	input wire logic [11:0] PADDR_I,
	input wire logic [31:0] PWDATA_I,
	output logic [31:0] PRDATA_O,
	output logic PREADY_O,
	output logic PSLVERR_O,
	input wire logic FIELD_SYNC_PULSE_I,
	input wire logic [gotu_pkg::GOTU_POS_W-1:0] LINE_CNT_I,
	input wire logic [gotu_pkg::GOTU_POS_W-1:0] PIXEL_CNT_I,
	input wire logic [gotu_pkg::GOTU_POS_W-1:0] MODE_CNT_I,
	input wire logic [gotu_pkg::GOTU_POS_W-1:0] PRI_CNT_I,
	input wire logic [gotu_pkg::GOTU_POS_W-1:0] SEC_CNT_I,
	input wire logic PRI_RUN_I,
	input wire logic SEC_RUN_I,
	input wire logic SUBSTRATE_CLOCK_COPY_I,
	input wire logic [3:0] EXTRA_VERTICAL_CLOCK_I,
	input wire logic INTERNAL_CLOCK_I,
	input wire logic OPTICAL_BLACK_CLAMP_PULSE_I,
	input wire logic DELAYED_SAMPLE_CLOCK_I,
	input wire logic [7:0] GENERAL_OUTPUT_PIN_I,
	output logic [7:0] GENERAL_OUTPUT_PIN_O,
	output logic [7:0] GENERAL_OUTPUT_PIN_OE_O
);
	import gotu_pkg::*;

	// ----------------------------------------------------------------
	// Declarations
	// ----------------------------------------------------------------
	gotu_link_t link_sel_ff [GOTU_NSIG];
	logic [7:0] start_level_ff;
	logic [7:0] pin_source_select_ff;
	logic [7:0] pin_drive_enable_ff;
	logic [7:0] table_route_enable_ff;
	logic internal_view_enable_ff;
	logic [GOTU_NPAIR-1:0][3:0] pair_logic_table_ff;
	logic [7:0] fire_arm_ff;
	logic [7:0] manual_act_ff;
	logic [GOTU_NPOS-1:0] fd_is1_ff;
	logic [7:0] level_ff;
	logic [7:0] pin_o_ff;
	logic [7:0] pin_oe_ff;

	gotu_bus_st_t bus_st_ff;
	logic pready_ff;
	logic pslverr_ff;
	logic [31:0] prdata_ff;

	logic [9:0] idx;
	logic is_pos;
	logic reg_hit;
	logic access;
	logic wr_done;
	logic mem_bus_rd;
	logic [31:0] reg_rdata;
	logic [4:0] pos_num;
	logic [1:0] pos_comp;

	logic [GOTU_NSIG-1:0] cand_v_ff;
	logic [GOTU_NSIG-1:0] done_ff;
	logic [1:0] ptr_ff [GOTU_NSIG];
	logic [GOTU_POS_W-1:0] cand_line_ff [GOTU_NSIG];
	logic [GOTU_POS_W-1:0] cand_pix_ff [GOTU_NSIG];
	logic rd_pend_ff;
	logic [2:0] rd_sig_ff;
	logic [GOTU_POS_W-1:0] count [GOTU_NSIG];
	logic [GOTU_NSIG-1:0] act;
	logic [GOTU_NSIG-1:0] need;
	logic [GOTU_NSIG-1:0] hit;
	logic [2:0] pick;
	logic fetch_go;
	logic [4:0] mem_rd_addr;
	gotu_pos_t mem_rd_data;
	logic [GOTU_NPAIR-1:0] lut_res;
	logic [7:0] sig_out;
	logic [7:0] pin_val;

	// ----------------------------------------------------------------
	// APB decode
	// ----------------------------------------------------------------
	assign idx = PADDR_I[11:2];
	assign pos_num = idx[6:2];
	assign pos_comp = idx[1:0];
	assign is_pos = (idx[9:7] == GOTU_IDX_POS_TOP) && (pos_comp != GOTU_COMP_NONE);
	assign reg_hit = (idx == GOTU_IDX_FIRE) || (idx == GOTU_IDX_LINK) || (idx == GOTU_IDX_PINCFG) ||
		(idx == GOTU_IDX_STATUS) || (idx == GOTU_IDX_TABLE);
	assign access = PSEL_I && PENABLE_I;
	// A write takes effect only on the edge where the master sees PREADY high.
	assign wr_done = access && pready_ff && PWRITE_I && !pslverr_ff;
	assign mem_bus_rd = (bus_st_ff == GOTU_BUS_IDLE) && access && !PWRITE_I && is_pos;

	always_comb
	begin
		reg_rdata = 32'h0000_0000;
		case (idx)
			GOTU_IDX_FIRE:
				reg_rdata[GOTU_FIRE_LSB +: 8] = fire_arm_ff; // [R17]
			GOTU_IDX_LINK:
				for (int i = 0; i < GOTU_NSIG; i++)
					reg_rdata[3*i +: 3] = link_sel_ff[i];
			GOTU_IDX_PINCFG:
			begin
				reg_rdata[7:0] = start_level_ff;
				reg_rdata[GOTU_PINCFG_SRC_LSB +: 8] = pin_source_select_ff;
				reg_rdata[GOTU_PINCFG_DRV_LSB +: 8] = pin_drive_enable_ff;
				reg_rdata[GOTU_PINCFG_VIEW_BIT] = internal_view_enable_ff;
			end
			GOTU_IDX_STATUS:
			begin
				reg_rdata[7:0] = level_ff;
				reg_rdata[GOTU_STATUS_PIN_LSB +: 8] = GENERAL_OUTPUT_PIN_I;
			end
			GOTU_IDX_TABLE:
			begin
				reg_rdata[7:0] = table_route_enable_ff;
				reg_rdata[GOTU_TABLE_LSB +: 16] = pair_logic_table_ff;
			end
			default:
				reg_rdata = 32'h0000_0000;
		endcase
	end

	// ----------------------------------------------------------------
	// APB handshake: one wait state for registers and position writes, two for position reads
	// ----------------------------------------------------------------
	always_ff @(posedge CLK_SYS_I or negedge RST_B_I)
	begin
		if (!RST_B_I)
		begin
			bus_st_ff <= GOTU_BUS_IDLE;
			pready_ff <= 1'b0;
			pslverr_ff <= 1'b0;
			prdata_ff <= 32'h0000_0000;
		end
		else
		begin
			case (bus_st_ff)
				GOTU_BUS_IDLE:
					if (mem_bus_rd)
						bus_st_ff <= GOTU_BUS_MEMWAIT;
					else if (access)
					begin
						bus_st_ff <= GOTU_BUS_DONE;
						pready_ff <= 1'b1;
						pslverr_ff <= !(is_pos || reg_hit);
						prdata_ff <= PWRITE_I ? 32'h0000_0000 : reg_rdata;
					end
				GOTU_BUS_MEMWAIT:
				begin
					bus_st_ff <= GOTU_BUS_DONE;
					pready_ff <= 1'b1;
					pslverr_ff <= 1'b0;
					case (pos_comp)
						GOTU_COMP_FIELD:
							prdata_ff <= {19'h0, mem_rd_data.field};
						GOTU_COMP_LINE:
							prdata_ff <= {19'h0, mem_rd_data.line};
						default:
							prdata_ff <= {19'h0, mem_rd_data.pixel};
					endcase
				end
				GOTU_BUS_DONE:
				begin
					bus_st_ff <= GOTU_BUS_IDLE;
					pready_ff <= 1'b0;
					pslverr_ff <= 1'b0;
					prdata_ff <= 32'h0000_0000;
				end
				default:
				begin
					bus_st_ff <= GOTU_BUS_IDLE;
					pready_ff <= 1'b0;
				end
			endcase
		end
	end

	assign PREADY_O = pready_ff;
	assign PSLVERR_O = pslverr_ff;
	assign PRDATA_O = prdata_ff;

	// ----------------------------------------------------------------
	// Configuration registers
	// ----------------------------------------------------------------
	always_ff @(posedge CLK_SYS_I or negedge RST_B_I)
	begin
		if (!RST_B_I)
		begin
			for (int i = 0; i < GOTU_NSIG; i++)
				link_sel_ff[i] <= GOTU_LINK_IDLE;
			start_level_ff <= 8'h00;
			pin_source_select_ff <= GOTU_RST_SRC_SEL;
			pin_drive_enable_ff <= GOTU_RST_DRV_EN;
			internal_view_enable_ff <= 1'b0;
			table_route_enable_ff <= 8'h00;
			pair_logic_table_ff <= '0;
		end
		else if (wr_done)
		begin
			if (idx == GOTU_IDX_LINK)
				for (int i = 0; i < GOTU_NSIG; i++)
					link_sel_ff[i] <= gotu_link_t'(PWDATA_I[3*i +: 3]);
			if (idx == GOTU_IDX_PINCFG)
			begin
				start_level_ff <= PWDATA_I[7:0];
				pin_source_select_ff <= PWDATA_I[GOTU_PINCFG_SRC_LSB +: 8];
				pin_drive_enable_ff <= PWDATA_I[GOTU_PINCFG_DRV_LSB +: 8];
				internal_view_enable_ff <= PWDATA_I[GOTU_PINCFG_VIEW_BIT];
			end
			if (idx == GOTU_IDX_TABLE)
			begin
				table_route_enable_ff <= PWDATA_I[7:0]; // [R10]
				pair_logic_table_ff <= PWDATA_I[GOTU_TABLE_LSB +: 16]; // [R11]
			end
		end
	end

	// ----------------------------------------------------------------
	// Manual fire: armed by a write, consumed at the next field sync
	// ----------------------------------------------------------------
	always_ff @(posedge CLK_SYS_I or negedge RST_B_I)
	begin
		if (!RST_B_I)
		begin
			fire_arm_ff <= 8'h00;
			manual_act_ff <= 8'h00;
		end
		else
		begin
			for (int i = 0; i < GOTU_NSIG; i++)
			begin
				// A write landing on the sync cycle keeps its bit for the next field.
				if (wr_done && idx == GOTU_IDX_FIRE && PWDATA_I[GOTU_FIRE_LSB + i])
					fire_arm_ff[i] <= 1'b1; // [R05] [R17]
				else if (FIELD_SYNC_PULSE_I)
					fire_arm_ff[i] <= 1'b0; // [R21]
			end
			if (FIELD_SYNC_PULSE_I)
				manual_act_ff <= fire_arm_ff; // [R16]
		end
	end

	// Tracks which toggles sit at field 1, for link selects 5 and 6.
	always_ff @(posedge CLK_SYS_I or negedge RST_B_I)
	begin
		if (!RST_B_I)
			fd_is1_ff <= '0;
		else if (wr_done && is_pos && pos_comp == GOTU_COMP_FIELD)
			fd_is1_ff[pos_num] <= (PWDATA_I[GOTU_POS_W-1:0] == GOTU_MANUAL_FIELD); // [R22]
	end

	// ----------------------------------------------------------------
	// Toggle position store
	// ----------------------------------------------------------------
	assign mem_rd_addr = mem_bus_rd ? pos_num : {pick, ptr_ff[pick]};

	gotu_pos_mem #(
		.DEPTH(GOTU_NPOS)
	) u_pos_mem (
		.CLK_SYS_I(CLK_SYS_I),
		.RST_B_I(RST_B_I),
		.wr_en_i(wr_done && is_pos),
		.wr_addr_i(pos_num),
		.wr_comp_i(pos_comp),
		.wr_data_i(PWDATA_I[GOTU_POS_W-1:0]),
		.rd_en_i(mem_bus_rd || fetch_go),
		.rd_addr_i(mem_rd_addr),
		.rd_data_o(mem_rd_data)
	);

	// ----------------------------------------------------------------
	// Linked count and activity per signal
	// ----------------------------------------------------------------
	always_comb
	begin
		for (int i = 0; i < GOTU_NSIG; i++)
		begin
			count[i] = '0;
			act[i] = 1'b0;
			case (link_sel_ff[i])
				GOTU_LINK_MANUAL:
				begin
					count[i] = GOTU_MANUAL_FIELD; // [R01]
					act[i] = manual_act_ff[i]; // [R01] [R16]
				end
				GOTU_LINK_MODE:
				begin
					count[i] = MODE_CNT_I; // [R02]
					act[i] = 1'b1;
				end
				GOTU_LINK_PRI:
				begin
					count[i] = PRI_CNT_I; // [R03]
					act[i] = PRI_RUN_I && |fd_is1_ff[GOTU_NTOG*i +: GOTU_NTOG]; // [R03] [R22]
				end
				GOTU_LINK_SEC:
				begin
					count[i] = SEC_CNT_I; // [R04]
					act[i] = SEC_RUN_I && |fd_is1_ff[GOTU_NTOG*i +: GOTU_NTOG]; // [R04] [R22]
				end
				default:
				begin
					count[i] = '0;
					act[i] = 1'b0;
				end
			endcase
			need[i] = act[i] && !cand_v_ff[i] && !done_ff[i];
			hit[i] = cand_v_ff[i] && act[i] && (LINE_CNT_I == cand_line_ff[i]) &&
				(PIXEL_CNT_I == cand_pix_ff[i]); // [R14] [R23]
		end
	end

	always_comb
	begin
		pick = 3'h0;
		for (int i = GOTU_NSIG - 1; i >= 0; i--)
			if (need[i])
				pick = 3'(i);
	end

	// The bus owns the read port when it needs it; the scanner waits.
	assign fetch_go = |need && !mem_bus_rd && !rd_pend_ff;

	// ----------------------------------------------------------------
	// Toggle scanner: walks each signal's toggles in order every field
	// ----------------------------------------------------------------
	always_ff @(posedge CLK_SYS_I or negedge RST_B_I)
	begin
		if (!RST_B_I)
		begin
			cand_v_ff <= '0;
			done_ff <= '0;
			rd_pend_ff <= 1'b0;
			rd_sig_ff <= 3'h0;
			for (int i = 0; i < GOTU_NSIG; i++)
			begin
				ptr_ff[i] <= 2'h0;
				cand_line_ff[i] <= '0;
				cand_pix_ff[i] <= '0;
			end
		end
		else if (FIELD_SYNC_PULSE_I)
		begin
			cand_v_ff <= '0;
			done_ff <= '0;
			rd_pend_ff <= 1'b0;
			for (int i = 0; i < GOTU_NSIG; i++)
				ptr_ff[i] <= 2'h0;
		end
		else
		begin
			rd_pend_ff <= fetch_go;
			rd_sig_ff <= pick;
			if (rd_pend_ff)
			begin
				if (mem_rd_data.field == count[rd_sig_ff])
				begin
					cand_v_ff[rd_sig_ff] <= 1'b1; // [R13]
					cand_line_ff[rd_sig_ff] <= mem_rd_data.line;
					cand_pix_ff[rd_sig_ff] <= mem_rd_data.pixel;
				end
				else if (ptr_ff[rd_sig_ff] == 2'h3)
					done_ff[rd_sig_ff] <= 1'b1;
				else
					ptr_ff[rd_sig_ff] <= ptr_ff[rd_sig_ff] + 2'h1;
			end
			for (int i = 0; i < GOTU_NSIG; i++)
				if (hit[i])
				begin
					cand_v_ff[i] <= 1'b0;
					if (ptr_ff[i] == 2'h3)
						done_ff[i] <= 1'b1; // [R16]
					else
						ptr_ff[i] <= ptr_ff[i] + 2'h1;
				end
		end
	end

	// ----------------------------------------------------------------
	// Signal levels
	// ----------------------------------------------------------------
	always_ff @(posedge CLK_SYS_I or negedge RST_B_I)
	begin
		if (!RST_B_I)
			level_ff <= 8'h00;
		else
			for (int i = 0; i < GOTU_NSIG; i++)
				case (link_sel_ff[i])
					GOTU_LINK_IDLE:
						level_ff[i] <= start_level_ff[i]; // [R06]
					GOTU_LINK_KEEP_ON:
						level_ff[i] <= 1'b1;
					default:
						if (hit[i])
							level_ff[i] <= !level_ff[i]; // [R23]
				endcase
	end

	// ----------------------------------------------------------------
	// Pair tables and routing
	// ----------------------------------------------------------------
	generate
		for (genvar p = 0; p < GOTU_NPAIR; p++)
		begin : g_pair
			gotu_pair_lut u_lut (
				.table_i(pair_logic_table_ff[p]),
				.lo_i(level_ff[2*p]),
				.hi_i(level_ff[2*p+1]),
				.res_o(lut_res[p])
			); // [R11] [R12]
		end
	endgenerate

	always_comb
	begin
		for (int i = 0; i < GOTU_NSIG; i++)
		begin
			sig_out[i] = table_route_enable_ff[i] ? lut_res[i/2] : level_ff[i]; // [R10]
			if (pin_source_select_ff[i])
				pin_val[i] = sig_out[i]; // [R07]
			else
				case (i)
					0:
						pin_val[i] = internal_view_enable_ff && INTERNAL_CLOCK_I; // [R15]
					1:
						pin_val[i] = internal_view_enable_ff && OPTICAL_BLACK_CLAMP_PULSE_I; // [R15]
					2:
						pin_val[i] = internal_view_enable_ff && DELAYED_SAMPLE_CLOCK_I; // [R15]
					3:
						pin_val[i] = SUBSTRATE_CLOCK_COPY_I; // [R08]
					default:
						pin_val[i] = EXTRA_VERTICAL_CLOCK_I[i-4]; // [R08]
				endcase
		end
	end

	// ----------------------------------------------------------------
	// Pin registers
	// ----------------------------------------------------------------
	always_ff @(posedge CLK_SYS_I or negedge RST_B_I)
	begin
		if (!RST_B_I)
		begin
			pin_o_ff <= 8'h00;
			pin_oe_ff <= 8'h00;
		end
		else
		begin
			pin_o_ff <= pin_val;
			pin_oe_ff <= pin_drive_enable_ff; // [R09]
		end
	end

	assign GENERAL_OUTPUT_PIN_O = pin_o_ff;
	assign GENERAL_OUTPUT_PIN_OE_O = pin_oe_ff;

endmodule : gotu_top

// [gotu_properties.sv]
// Checker for the toggle unit: pin muxing, drive enables and bus answers.
// Assumes it is bound to gotu_top and sees only that module's ports.
`timescale 1ns/1ps

module gotu_properties
	import gotu_pkg::*;
(
	input wire logic CLK_SYS_I,
	input wire logic RST_B_I,
	input wire logic PSEL_I,
	input wire logic PENABLE_I,
	input wire logic PWRITE_I,
	input wire logic [11:0] PADDR_I,
	input wire logic [31:0] PWDATA_I,
	input wire logic [31:0] PRDATA_O,
	input wire logic PREADY_O,
	input wire logic PSLVERR_O,
	input wire logic SUBSTRATE_CLOCK_COPY_I,
	input wire logic [3:0] EXTRA_VERTICAL_CLOCK_I,
	input wire logic INTERNAL_CLOCK_I,
	input wire logic OPTICAL_BLACK_CLAMP_PULSE_I,
	input wire logic DELAYED_SAMPLE_CLOCK_I,
	input wire logic [7:0] GENERAL_OUTPUT_PIN_O,
	input wire logic [7:0] GENERAL_OUTPUT_PIN_OE_O
);
	// ----------------------------------------------------------------
	// Shadow of the pin configuration word
	// ----------------------------------------------------------------
	logic cfg_wr;
	logic [7:0] src_ff;
	logic [7:0] drv_ff;
	logic view_ff;
	logic [1:0] quiet_ff;
	logic quiet;

	assign cfg_wr = PSEL_I && PENABLE_I && PWRITE_I && PREADY_O && (PADDR_I[11:2] == GOTU_IDX_PINCFG);
	assign quiet = (quiet_ff == 2'h3);

	// Pins lag the register by one cycle, so checks wait until the shadow has settled.
	always_ff @(posedge CLK_SYS_I or negedge RST_B_I)
	begin
		if (!RST_B_I)
		begin
			src_ff <= GOTU_RST_SRC_SEL;
			drv_ff <= GOTU_RST_DRV_EN;
			view_ff <= 1'b0;
			quiet_ff <= 2'h0;
		end
		else if (cfg_wr)
		begin
			src_ff <= PWDATA_I[15:8];
			drv_ff <= PWDATA_I[23:16];
			view_ff <= PWDATA_I[24];
			quiet_ff <= 2'h0;
		end
		else if (!quiet)
			quiet_ff <= quiet_ff + 2'h1;
	end

	default clocking cb @(posedge CLK_SYS_I);
	endclocking
	default disable iff (!RST_B_I);

	oe_follow_a: assert property (quiet |-> GENERAL_OUTPUT_PIN_OE_O == drv_ff)
		else $error("pin drive enable differs from its setting");
	oe_reset_a: assert property (!$past(RST_B_I) |-> GENERAL_OUTPUT_PIN_OE_O == 8'h00)
		else $error("pins driven right after reset");
	subst_pin_a: assert property (quiet && !src_ff[3] |->
		GENERAL_OUTPUT_PIN_O[3] == $past(SUBSTRATE_CLOCK_COPY_I))
		else $error("pin 4 does not show the substrate copy");
	vclk_pins_a: assert property (quiet && src_ff[7:4] == 4'h0 |->
		GENERAL_OUTPUT_PIN_O[7:4] == $past(EXTRA_VERTICAL_CLOCK_I))
		else $error("pins 5 to 8 do not show the extra vertical clocks");
	view_pins_a: assert property (quiet && view_ff && src_ff[2:0] == 3'h0 |->
		GENERAL_OUTPUT_PIN_O[0] == $past(INTERNAL_CLOCK_I) && GENERAL_OUTPUT_PIN_O[1] == $past(OPTICAL_BLACK_CLAMP_PULSE_I)
		&& GENERAL_OUTPUT_PIN_O[2] == $past(DELAYED_SAMPLE_CLOCK_I))
		else $error("pins 1 to 3 do not show the internal signals");
	dark_pins_a: assert property (quiet && !view_ff && src_ff[2:0] == 3'h0 |-> GENERAL_OUTPUT_PIN_O[2:0] == 3'h0)
		else $error("pins 1 to 3 not low with view off");
	ready_pulse_a: assert property (PREADY_O |=> !PREADY_O)
		else $error("ready stands longer than one cycle");
	rdata_idle_a: assert property (!PREADY_O |-> PRDATA_O == 32'h0)
		else $error("read data outside the answer cycle");
	slverr_ready_a: assert property (PSLVERR_O |-> PREADY_O)
		else $error("error flag without ready");

	cover property (cfg_wr);
	cover property (PSLVERR_O);
	cover property (quiet && view_ff);
endmodule : gotu_properties

bind gotu_top gotu_properties u_props (.CLK_SYS_I, .RST_B_I, .PSEL_I, .PENABLE_I, .PWRITE_I, .PADDR_I,
	.PWDATA_I, .PRDATA_O, .PREADY_O, .PSLVERR_O, .SUBSTRATE_CLOCK_COPY_I, .EXTRA_VERTICAL_CLOCK_I,
	.INTERNAL_CLOCK_I, .OPTICAL_BLACK_CLAMP_PULSE_I, .DELAYED_SAMPLE_CLOCK_I, .GENERAL_OUTPUT_PIN_O,
	.GENERAL_OUTPUT_PIN_OE_O);

// [gotu_pin_load.sv]
// External load on the eight bidirectional pins.
// Assumes no pull resistors; an undriven pin wanders each cycle.
`timescale 1ns/1ps

module gotu_pin_load (
	input wire logic CLK_SYS_I,
	input wire logic [7:0] pin_o_i,
	input wire logic [7:0] pin_oe_i,
	output logic [7:0] pin_lvl_o
);
	// ----------------------------------------------------------------
	// Wire resolution
	// ----------------------------------------------------------------
	logic [7:0] last_ff = 8'h00;

	// A released pin shows the inverse of its last level, so stale data never looks valid.
	assign pin_lvl_o = (pin_oe_i & pin_o_i) | (~pin_oe_i & ~last_ff);

	always_ff @(posedge CLK_SYS_I)
		last_ff <= pin_lvl_o;
endmodule : gotu_pin_load

// [tb_top.sv]
// Self-checking bench for the toggle unit over APB.
// Assumes the bench plays the timing generator and the pins see gotu_pin_load.
`timescale 1ns/1ps

module tb_top;
	import gotu_pkg::*;
	// ----------------------------------------------------------------
	// Stimulus and checks
	// ----------------------------------------------------------------
	logic clk = 1'b0;
	logic rst_b = 1'b0;
	logic psel = 1'b0;
	logic pen = 1'b0;
	logic pwr = 1'b0;
	logic sync = 1'b0;
	logic se;
	logic pready;
	logic pslverr;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic [31:0] rdv;
	logic [12:0] line = 13'h0;
	logic [12:0] pixel = 13'h0;
	logic [12:0] mode_c = 13'h3;
	logic [12:0] pri_c = 13'h1;
	logic [12:0] sec_c = 13'h1;
	logic [12:0] fld [5] = '{13'h1, 13'h1, 13'h2, 13'h1, 13'h3};
	logic [7:0] pin_o;
	logic [7:0] pin_oe;
	logic [7:0] pin_lvl;
	int err_count = 0;
	int checked = 0;

	always #5 clk = ~clk;

	gotu_top u_dut (.CLK_SYS_I(clk), .RST_B_I(rst_b), .PSEL_I(psel), .PENABLE_I(pen), .PWRITE_I(pwr),
		.PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata), .PREADY_O(pready), .PSLVERR_O(pslverr),
		.FIELD_SYNC_PULSE_I(sync), .LINE_CNT_I(line), .PIXEL_CNT_I(pixel), .MODE_CNT_I(mode_c),
		.PRI_CNT_I(pri_c), .SEC_CNT_I(sec_c), .PRI_RUN_I(1'b1), .SEC_RUN_I(1'b1),
		.SUBSTRATE_CLOCK_COPY_I(sync), .EXTRA_VERTICAL_CLOCK_I(4'hA), .INTERNAL_CLOCK_I(pen),
		.OPTICAL_BLACK_CLAMP_PULSE_I(1'b0), .DELAYED_SAMPLE_CLOCK_I(1'b1), .GENERAL_OUTPUT_PIN_I(pin_lvl),
		.GENERAL_OUTPUT_PIN_O(pin_o), .GENERAL_OUTPUT_PIN_OE_O(pin_oe));

	gotu_pin_load u_load (.CLK_SYS_I(clk), .pin_o_i(pin_o), .pin_oe_i(pin_oe), .pin_lvl_o(pin_lvl));

	task print_verdict;
		$display("checks %0d errors %0d", checked, err_count);
		if (err_count == 0 && checked > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : print_verdict

	task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		checked++;
		if (got !== exp)
		begin
			err_count++;
			$display("[ERR] %s expected %h seen %h", nm, exp, got);
		end
	endtask : chk

	// Ready is sampled at a rising edge; the request is released right after that edge.
	task apb(input logic w, input logic [9:0] idx, input logic [31:0] wd);
		int n;
		@(posedge clk);
		psel <= 1'b1;
		pwr <= w;
		paddr <= {idx, 2'b00};
		pwdata <= wd;
		@(posedge clk);
		pen <= 1'b1;
		n = 0;
		@(posedge clk);
		while (pready !== 1'b1 && n < 40)
		begin
			@(posedge clk);
			n++;
		end
		if (n >= 40)
			err_count++;
		rdv = prdata;
		se = pslverr;
		psel <= 1'b0;
		pen <= 1'b0;
	endtask : apb

	// One field: sync pulse, fetch window, then a pixel sweep along line 10.
	task run_field;
		@(posedge clk);
		sync <= 1'b1;
		@(posedge clk);
		sync <= 1'b0;
		repeat (20) @(posedge clk);
		line <= 13'h00A;
		for (int p = 0; p < 8; p++)
		begin
			pixel <= 13'(p);
			@(posedge clk);
		end
		line <= 13'h0;
		pixel <= 13'h0;
		repeat (4) @(posedge clk);
	endtask : run_field

	initial
	begin
		#200000;
		err_count++;
		print_verdict();
	end

	initial
	begin
		repeat (16) @(posedge clk);
		rst_b <= 1'b1;
		apb(1'b0, GOTU_IDX_PINCFG, 32'h0);
		chk("pincfg reset", 32'h0000FF00, rdv);
		apb(1'b0, 10'h083, 32'h0);
		chk("unmapped error", 32'h1, {31'h0, se});
		for (int s = 0; s < 5; s++)
		begin
			apb(1'b1, 10'h080 + 10'(16 * s), {19'h0, fld[s]});
			apb(1'b1, 10'h081 + 10'(16 * s), 32'h00A);
			apb(1'b1, 10'h082 + 10'(16 * s), 32'h002);
		end
		apb(1'b1, GOTU_IDX_PINCFG, 32'h0000FF40);
		apb(1'b1, GOTU_IDX_LINK, {8'h0, 3'h0, 3'h0, 3'h7, 3'h4, 3'h6, 3'h6, 3'h5, 3'h1});
		apb(1'b0, GOTU_IDX_LINK, 32'h0);
		chk("link selects", 32'h0003CDA9, rdv);
		apb(1'b1, GOTU_IDX_FIRE, 32'h40);
		apb(1'b0, GOTU_IDX_FIRE, 32'h0);
		chk("fire armed", 32'h40, rdv);
		run_field();
		apb(1'b0, GOTU_IDX_FIRE, 32'h0);
		chk("fire cleared", 32'h0, rdv);
		apb(1'b0, GOTU_IDX_STATUS, 32'h0);
		chk("levels field A", 32'h7B, {24'h0, rdv[7:0]});
		apb(1'b1, GOTU_IDX_TABLE, 32'h006E8655);
		apb(1'b1, GOTU_IDX_PINCFG, 32'h00FFFF40);
		repeat (3) @(posedge clk);
		chk("pins table", 32'hFF7A, {16'h0, pin_oe, pin_o});
		apb(1'b0, GOTU_IDX_STATUS, 32'h0);
		chk("pin inputs", 32'h7A, {24'h0, rdv[15:8]});
		apb(1'b1, GOTU_IDX_PINCFG, 32'h01FF0040);
		repeat (3) @(posedge clk);
		chk("pins vertical view", 32'hA4, {24'h0, pin_o});
		apb(1'b1, GOTU_IDX_PINCFG, 32'h000000FF);
		repeat (3) @(posedge clk);
		chk("pins released", 32'h0, {24'h0, pin_oe});
		pri_c <= 13'h2;
		sec_c <= 13'h2;
		mode_c <= 13'h4;
		run_field();
		apb(1'b0, GOTU_IDX_STATUS, 32'h0);
		chk("levels field B", 32'hFB, {24'h0, rdv[7:0]});
		print_verdict();
	end
endmodule : tb_top
